// >>> bench/cpw_clock_prescaler_sva.sv
// Checker for the clock prescaler block, bound to its top ports.
// Assumes one clock domain and presetn as its reset.
`timescale 1ns/1ps
module cpw_clock_prescaler_sva (
  input wire logic pclk, // System clock
  input wire logic presetn, // Reset, active low
  input wire logic clk_en, // Run enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic subclock_xtal_in, // Crystal subclock
  input wire logic ext_subclock_in, // External subclock
  input wire logic wake_accept, // Wake accepted
  input wire logic osc_stable, // Oscillator stable
  input wire logic osc_enable, // Oscillator request
  input wire logic cpu_hold, // CPU hold
  input cpw_pkg::cpw_ticks_t ticks // Divided enables
);
  // ==========
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence halted_s;
    cpu_hold && !osc_enable;
  endsequence
  sequence restart_s;
    $rose(osc_enable) && cpu_hold;
  endsequence
  chk_sys_nest: assert property (
    ticks.sys[1] |-> ticks.sys[0]) else $error("sys tap 1 without tap 0");
  chk_sys_pulse: assert property (
    ticks.sys[0] |=> !ticks.sys[0]) else $error("sys tap longer than one cycle");
  chk_watch_pulse: assert property (
    ticks.watch[0] |=> !ticks.watch[0]) else $error("watch tap longer than one cycle");
  chk_halt_zero: assert property (
    !osc_enable [*3] |-> ticks.sys == 13'h0000) else $error("sys taps while halted");
  chk_halt_osc_off: assert property (
    $rose(cpu_hold) |-> !osc_enable) else $error("oscillator kept on at halt");
  chk_stay_halted: assert property (
    halted_s ##0 !wake_accept |=> !osc_enable) else $error("restart without wake");
  chk_wake_restart: assert property (
    halted_s ##0 wake_accept |=> osc_enable && cpu_hold) else $error("wake not taken");
  chk_min_wait: assert property (
    restart_s |=> cpu_hold [*8]) else $error("hold shorter than minimum wait");
  chk_release_stable: assert property (
    $fell(cpu_hold) |-> osc_enable && $past(osc_stable, 8)) else $error("release too early");
  chk_release_bound: assert property (
    restart_s |-> ##[1:300] !cpu_hold) else $error("hold never released");
endmodule : cpw_clock_prescaler_sva

// >>> bench/cpw_osc_model.sv
// Oscillator partner: reports stable some cycles after the run request.
// Assumes the block's pclk and presetn.
`timescale 1ns/1ps
module cpw_osc_model #(
  parameter int START = 5
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Reset, active low
  input wire logic slow, // Stretches start-up fourfold
  input wire logic osc_enable, // Run request
  output logic osc_stable // Oscillator stable
);
  // ==========
  // Start-up
  logic [7:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      osc_stable <= 1'b1;
    end else if (!osc_enable) begin
      // A halted oscillator is never reported stable
      cnt <= 8'h00;
      osc_stable <= 1'b0;
    end else if (cnt < (slow ? 8'(4 * START) : 8'(START))) begin
      cnt <= cnt + 8'h01;
    end else begin
      osc_stable <= 1'b1;
    end
  end
endmodule : cpw_osc_model

// >>> bench/tb.sv
// Self-checking bench for the clock prescaler block.
// Assumes the design, package, oscillator model and checker are compiled first.
`timescale 1ns/1ps
module tb;
  localparam logic [7:0][17:0] WL = {18'h28, 18'h20, 18'h1C, 18'h18,
    18'h14, 18'h10, 18'h0C, 18'h08};
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, slow = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wake_accept = 1'b0;
  logic subclock_xtal_in = 1'b0, ext_subclock_in = 1'b0, counting = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, osc_stable, osc_enable, cpu_hold, err;
  cpw_pkg::cpw_ticks_t ticks;
  int fail_count = 0, num_checks = 0, n;
  int scnt[13], wcnt[8];
  always #25 pclk = ~pclk;
  cpw_clock_prescaler #(.WAIT_LEN(WL)) u_cpw_clock_prescaler (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .subclock_xtal_in(subclock_xtal_in), .ext_subclock_in(ext_subclock_in),
    .wake_accept(wake_accept), .osc_stable(osc_stable), .osc_enable(osc_enable),
    .cpu_hold(cpu_hold), .ticks(ticks));
  cpw_osc_model u_cpw_osc_model (.pclk(pclk), .presetn(presetn), .slow(slow),
    .osc_enable(osc_enable), .osc_stable(osc_stable));
  always @(posedge pclk) if (counting) begin
    for (int k = 0; k < 13; k++) begin
      if (ticks.sys[k] === 1'b1) scnt[k]++;
      if (k < 8 && ticks.watch[k] === 1'b1) wcnt[k]++;
    end
  end
  // ==========
  // Tasks
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    @(negedge pclk);
    while (pready !== 1'b1 && w < 16) begin
      @(negedge pclk);
      w++;
    end
    if (w == 16) fail_count++;
    @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Counts tap pulses over cyc cycles plus any subclock rises
  task run(input int cyc, input int rises, input logic ext);
    foreach (scnt[k]) scnt[k] = 0;
    foreach (wcnt[k]) wcnt[k] = 0;
    @(posedge pclk);
    counting <= 1'b1;
    repeat (cyc) @(posedge pclk);
    for (int i = 0; i < rises; i++) begin
      if (ext) ext_subclock_in <= 1'b1;
      else subclock_xtal_in <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_subclock_in <= 1'b0;
      subclock_xtal_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    counting <= 1'b0;
  endtask : run
  // ==========
  // Scenarios
  task t_regs;
    apb(0, 8'h10, 32'h0000_0000);
    check("status_reset", rd & 32'h0000_1FCF, 32'h0000_0008);
    check("mapped_err", {31'h0000_0000, err}, 32'h0000_0000);
    apb(0, 8'h14, 32'h0000_0000);
    check("unmapped_err", {31'h0000_0000, err}, 32'h0000_0001);
    check("unmapped_rd", rd, 32'h0000_0000);
    clk_en <= 1'b0;
    apb(1, 8'h00, 32'h0000_0070);
    clk_en <= 1'b1;
    apb(0, 8'h00, 32'h0000_0000);
    check("ctl_frozen", rd & 32'h0000_0070, 32'h0000_0000);
    apb(1, 8'h00, 32'hFFFF_FFFF);
    apb(0, 8'h00, 32'h0000_0000);
    check("ctl_field", rd & 32'h0000_0070, 32'h0000_0070);
  endtask : t_regs
  task t_sys;
    apb(1, 8'h0C, 32'h0000_0006);
    run(8192, 0, 1'b0);
    for (int k = 0; k < 13; k++) check("sys_tap", scnt[k], 8192 >> (k + 1));
    for (int s = 0; s < 4; s++) begin
      apb(1, 8'h0C, 32'(s << 4) | (s[0] ? 32'h0000_0007 : 32'h0000_0001));
      repeat (300) @(posedge pclk);
      run(1024, 0, 1'b0);
      check("medium_tap", scnt[0], 32 >> s);
    end
    apb(1, 8'h0C, 32'h0000_0000);
  endtask : t_sys
  task t_watch;
    run(0, 128, 1'b0);
    for (int k = 0; k < 8; k++) check("watch_tap", wcnt[k], 128 >> k);
    apb(1, 8'h08, 32'h0000_0001);
    run(0, 8, 1'b1);
    check("ext_sub", wcnt[0], 8);
    run(0, 4, 1'b0);
    check("xtal_ignored", wcnt[0], 0);
    apb(1, 8'h08, 32'h0000_0000);
  endtask : t_watch
  task t_wake;
    // Every wait code is tried, with the bench's short WL lengths in place of the long settings
    for (int sel = 0; sel < 8; sel++) begin
      slow <= sel[0];
      apb(1, 8'h00, 32'(sel << 4));
      apb(1, 8'h0C, 32'(2 + sel % 4));
      apb(0, 8'h10, 32'h0000_0000);
      check("halted", rd & 32'h0000_000F, 32'h0000_0005);
      if (sel == 0) begin
        run(0, 6, 1'b0);
        apb(0, 8'h10, 32'h0000_0000);
        check("watch_halt", rd & 32'h0000_1FC0, 32'h0000_0380);
      end
      run(20, 0, 1'b0);
      check("halt_sys", scnt[0], 0);
      wake_accept <= 1'b1;
      @(posedge pclk);
      wake_accept <= 1'b0;
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (osc_stable !== 1'b1 && n < 200);
      @(posedge pclk);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
        @(negedge pclk);
      end while (cpu_hold === 1'b1 && n < 300);
      check("wait_len", n, 32'(WL[sel]));
      apb(0, 8'h0C, 32'h0000_0000);
      check("mode_after", rd & 32'h0000_0007, 32'h0000_0000);
    end
    apb(1, 8'h04, 32'h0000_000C);
    apb(0, 8'h10, 32'h0000_0000);
    check("watch_clr", rd & 32'h0000_1FC0, 32'h0000_0080);
  endtask : t_wake
  // ==========
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_watch();
    t_sys();
    t_wake();
    final_report();
  end
  initial begin
    #(40000 * 50);
    fail_count++;
    final_report();
  end
endmodule : tb
bind cpw_clock_prescaler cpw_clock_prescaler_sva u_chk (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .subclock_xtal_in(subclock_xtal_in), .ext_subclock_in(ext_subclock_in),
  .wake_accept(wake_accept), .osc_stable(osc_stable), .osc_enable(osc_enable),
  .cpu_hold(cpu_hold), .ticks(ticks));

// >>> rtl/cpw_clock_prescaler.sv
// Clock prescalers, subclock select and wake-up wait sequencer with APB registers.
// Assumes pclk is the system clock reference, subclock pins are synchronous samples,
// and an outside oscillator model honours osc_enable and reports osc_stable.
`timescale 1ns/1ps
`include "cpw_defines.svh"

module cpw_clock_prescaler #(
  parameter logic [7:0][17:0] WAIT_LEN = {
    18'd131072, 18'd16384, 18'd8192, 18'd4096,
    18'd2048, 18'd1024, 18'd16, 18'd8
  }
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low, except ticks, which are cleared
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic subclock_xtal_in, // Crystal subclock sample
  input wire logic ext_subclock_in, // External subclock pin sample
  input wire logic wake_accept, // Wake interrupt accepted pulse
  input wire logic osc_stable, // System oscillator stabilised
  output logic osc_enable, // System oscillator run request
  output logic cpu_hold, // Holds CPU and peripherals
  output cpw_pkg::cpw_ticks_t ticks // Divided clock enables
);

  // ==========================================
  // Helper functions
  function automatic logic is_halting(input logic [2:0] mode);
    is_halting = (mode == `CPW_MODE_STANDBY) || (mode == `CPW_MODE_WATCH) ||
                 (mode == `CPW_MODE_SUBACTIVE) || (mode == `CPW_MODE_SUBSLEEP);
  endfunction : is_halting

  function automatic logic is_medium(input logic [2:0] mode);
    is_medium = (mode == `CPW_MODE_ACTIVE_MED) || (mode == `CPW_MODE_SLEEP_MED);
  endfunction : is_medium

  // Bit i of the result pulses when bits i..0 carry out on an advance
  function automatic logic [12:0] carry_taps(input logic [12:0] cnt, input logic adv);
    logic [12:0] t;
    t = 13'h0000;
    t[0] = adv && cnt[0];
    // Chained AND keeps every select constant, unlike a loop-indexed part-select
    for (int i = 1; i < 13; i++) begin
      t[i] = t[i - 1] && cnt[i];
    end
    carry_taps = t;
  endfunction : carry_taps

  // ==========================================
  // Register state
  logic [2:0] wake_wait_select;
  logic [3:0] timekeeper_mode_reg;
  logic ext_subclock_select;
  logic [2:0] power_mode;
  logic [1:0] med_div_sel;
  cpw_pkg::cpw_state_t state;
  logic [`CPW_SYS_BITS-1:0] sys_clock_prescaler;
  logic [`CPW_WATCH_BITS-1:0] watch_clock_prescaler;
  logic [1:0] watch_div4;
  logic [6:0] med_div;
  logic [`CPW_WAIT_BITS-1:0] wait_cnt;
  logic sub_prev;

  // ==========================================
  // APB decode
  logic setup_ph;
  logic wr_en;
  logic addr_ok;
  logic wr_sysctl;
  logic wr_tk;
  logic wr_port;
  logic wr_pwr;

  assign setup_ph = psel && !penable;
  assign addr_ok = (paddr == `CPW_OFS_SYS_CONTROL_ONE) ||
                   (paddr == `CPW_OFS_TIMEKEEPER_MODE) ||
                   (paddr == `CPW_OFS_PORT_MODE_TWO) ||
                   (paddr == `CPW_OFS_POWER_MODE) ||
                   (paddr == `CPW_OFS_STATUS);
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && clk_en;
  assign wr_sysctl = wr_en && (paddr == `CPW_OFS_SYS_CONTROL_ONE);
  assign wr_tk = wr_en && (paddr == `CPW_OFS_TIMEKEEPER_MODE);
  assign wr_port = wr_en && (paddr == `CPW_OFS_PORT_MODE_TWO);
  assign wr_pwr = wr_en && (paddr == `CPW_OFS_POWER_MODE);

  // ==========================================
  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_wait_select <= `CPW_RST_WAIT_SEL;
    end else if (wr_sysctl) begin
      wake_wait_select <= pwdata[`CPW_WAIT_SEL_MSB:`CPW_WAIT_SEL_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timekeeper_mode_reg <= `CPW_RST_TK_MODE;
    end else if (wr_tk) begin
      timekeeper_mode_reg <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_subclock_select <= 1'b0;
    end else if (wr_port) begin
      ext_subclock_select <= pwdata[`CPW_EXT_SUB_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      med_div_sel <= `CPW_RST_MED_SEL;
    end else if (wr_pwr) begin
      med_div_sel <= pwdata[`CPW_MED_SEL_MSB:`CPW_MED_SEL_LSB];
    end
  end

  // Status read-back; the system prescaler count is deliberately absent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && setup_ph && !pwrite) begin
      unique case (paddr)
        `CPW_OFS_SYS_CONTROL_ONE: prdata <= {25'h0, wake_wait_select, 4'h0};
        `CPW_OFS_TIMEKEEPER_MODE: prdata <= {28'h0, timekeeper_mode_reg};
        `CPW_OFS_PORT_MODE_TWO: prdata <= {31'h0, ext_subclock_select};
        `CPW_OFS_POWER_MODE: prdata <= {26'h0, med_div_sel, 1'b0, power_mode};
        `CPW_OFS_STATUS: prdata <= {19'h0, watch_clock_prescaler, watch_div4,
                                    2'h0, osc_enable, cpu_hold, state};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // Wake sequencer
  logic enter_low;
  logic wait_done;
  logic [`CPW_WAIT_BITS-1:0] wait_last;

  // Mode writes outside RUN are refused, so they must not stop the oscillator
  assign enter_low = wr_pwr && (state == cpw_pkg::CPW_RUN) && is_halting(pwdata[2:0]);
  assign wait_last = WAIT_LEN[wake_wait_select] - 18'd1;
  assign wait_done = (wait_cnt == wait_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cpw_pkg::CPW_RUN;
    end else if (clk_en) begin
      unique case (state)
        cpw_pkg::CPW_RUN: begin
          if (enter_low) begin
            state <= cpw_pkg::CPW_HALTED;
          end
        end
        cpw_pkg::CPW_HALTED: begin
          if (wake_accept) begin
            state <= cpw_pkg::CPW_OSC_START;
          end
        end
        cpw_pkg::CPW_OSC_START: begin
          if (osc_stable) begin
            state <= cpw_pkg::CPW_WAIT;
          end
        end
        cpw_pkg::CPW_WAIT: begin
          if (wait_done) begin
            state <= cpw_pkg::CPW_RUN;
          end
        end
      endcase
    end
  end

  // Counts system clock states once the oscillator is stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 18'h0_0000;
    end else if (clk_en) begin
      if (state == cpw_pkg::CPW_WAIT && !wait_done) begin
        wait_cnt <= wait_cnt + 18'd1;
      end else begin
        wait_cnt <= 18'h0_0000;
      end
    end
  end

  // Mode register; on release the device always lands in high-speed active mode, since no halting mode is medium
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_mode <= `CPW_MODE_ACTIVE_HIGH;
    end else if (clk_en) begin
      if (state == cpw_pkg::CPW_WAIT && wait_done) begin
        power_mode <= is_medium(power_mode) ? `CPW_MODE_ACTIVE_MED
                                            : `CPW_MODE_ACTIVE_HIGH;
      end else if (wr_pwr && state == cpw_pkg::CPW_RUN) begin
        power_mode <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable <= 1'b1;
      cpu_hold <= 1'b0;
    end else if (clk_en) begin
      osc_enable <= !(state == cpw_pkg::CPW_HALTED && !wake_accept) && !enter_low;
      cpu_hold <= (state != cpw_pkg::CPW_RUN && !(state == cpw_pkg::CPW_WAIT && wait_done))
                  || enter_low;
    end
  end

  // ==========================================
  // System clock prescaler
  logic sys_run;
  logic sys_adv;
  logic med_tick;
  logic [6:0] med_mask;

  assign sys_run = (state == cpw_pkg::CPW_RUN);
  assign med_mask = 7'((`CPW_MED_BASE << med_div_sel) | `CPW_MED_BASE);
  assign med_tick = ((med_div & med_mask) == med_mask);
  // In medium speed the prescaler advances once per selected oscillator division
  assign sys_adv = sys_run && (!is_medium(power_mode) || med_tick);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      med_div <= 7'h00;
    end else if (clk_en) begin
      if (!sys_run || !is_medium(power_mode) || med_tick) begin
        med_div <= 7'h00;
      end else begin
        med_div <= med_div + 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clock_prescaler <= 13'h0000;
    end else if (clk_en) begin
      if (!sys_run) begin
        sys_clock_prescaler <= 13'h0000;
      end else if (sys_adv) begin
        sys_clock_prescaler <= sys_clock_prescaler + 13'h0001;
      end
    end
  end

  // ==========================================
  // Subclock select and watch clock prescaler
  logic sub_sel;
  logic watch_edge;
  logic div4_tick;
  logic tk_clear;
  logic [12:0] watch_taps;

  assign sub_sel = ext_subclock_select ? ext_subclock_in : subclock_xtal_in;
  // Pins are already synchronous, so one stage suffices for edge detection
  assign watch_edge = sub_sel && !sub_prev;
  assign div4_tick = watch_edge && (watch_div4 == 2'h3);
  assign tk_clear = wr_tk && pwdata[`CPW_TK_BIT_THREE] && pwdata[`CPW_TK_BIT_TWO];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_prev <= 1'b0;
    end else if (clk_en) begin
      sub_prev <= sub_sel;
    end
  end

  // Watch path ignores the power mode: it only needs subclock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_div4 <= 2'h0;
    end else if (clk_en && watch_edge) begin
      watch_div4 <= watch_div4 + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_clock_prescaler <= 5'h00;
    end else if (clk_en) begin
      if (tk_clear) begin
        watch_clock_prescaler <= 5'h00;
      end else if (div4_tick) begin
        watch_clock_prescaler <= watch_clock_prescaler + 5'h01;
      end
    end
  end

  assign watch_taps = carry_taps({6'h00, watch_clock_prescaler, watch_div4}, watch_edge);

  // ==========================================
  // Divided clock enables
  // Registered pulses cost one cycle of latency but keep outputs glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ticks <= '0;
    end else if (clk_en) begin
      ticks.sys <= carry_taps(sys_clock_prescaler, sys_adv);
      ticks.watch <= {watch_taps[6:0] & {7{!tk_clear}}, watch_edge};
    end else begin
      ticks <= '0;
    end
  end

endmodule : cpw_clock_prescaler

// >>> rtl/cpw_defines.svh
// Offsets, field positions, reset values and codes of the clock prescaler block.
// Assumes inclusion by bare name from the design file only.
`ifndef CPW_DEFINES_SVH
`define CPW_DEFINES_SVH
// ==========================================
// Register byte offsets
`define CPW_OFS_SYS_CONTROL_ONE 8'h00
`define CPW_OFS_TIMEKEEPER_MODE 8'h04
`define CPW_OFS_PORT_MODE_TWO 8'h08
`define CPW_OFS_POWER_MODE 8'h0C
`define CPW_OFS_STATUS 8'h10
// ==========================================
// Field positions and reset values
`define CPW_WAIT_SEL_LSB 4
`define CPW_WAIT_SEL_MSB 6
`define CPW_TK_BIT_TWO 2
`define CPW_TK_BIT_THREE 3
`define CPW_EXT_SUB_BIT 0
`define CPW_MED_SEL_LSB 4
`define CPW_MED_SEL_MSB 5
`define CPW_RST_WAIT_SEL 3'h0
`define CPW_RST_TK_MODE 4'h0
`define CPW_RST_MED_SEL 2'h0
// ==========================================
// Operating mode codes
`define CPW_MODE_ACTIVE_HIGH 3'h0
`define CPW_MODE_ACTIVE_MED 3'h1
`define CPW_MODE_SUBACTIVE 3'h2
`define CPW_MODE_SUBSLEEP 3'h3
`define CPW_MODE_WATCH 3'h4
`define CPW_MODE_STANDBY 3'h5
`define CPW_MODE_SLEEP_HIGH 3'h6
`define CPW_MODE_SLEEP_MED 3'h7
// ==========================================
// Counter widths and dividers
`define CPW_SYS_BITS 13
`define CPW_WATCH_BITS 5
`define CPW_WAIT_BITS 18
`define CPW_MED_BASE 7'h0F
`endif

// >>> rtl/cpw_pkg.sv
// Types shared by the clock prescaler block and its bench.
// Assumes the defines header is compiled alongside.
package cpw_pkg;
  // ==========================================
  // Wake sequencer states
  typedef enum logic [1:0] {
    CPW_RUN,
    CPW_HALTED,
    CPW_OSC_START,
    CPW_WAIT
  } cpw_state_t;

  // ==========================================
  // Divided-clock enable pulses
  typedef struct packed {
    logic [12:0] sys;
    logic [7:0] watch;
  } cpw_ticks_t;
endpackage : cpw_pkg
